// *** hrlc_defs.svh ***
/*
 * constants of the health-report and host-lock command block:
 * command codes, signatures, sector layouts, register offsets, event bits.
 * assumes it is included by its bare name wherever the numbers are needed.
 */
`ifndef HRLC_DEFS_SVH
`define HRLC_DEFS_SVH

// ============================================================
// task-file command codes
`define HRLC_CMD_SMART    8'hb0
`define HRLC_CMD_LOCK     8'h83
`define HRLC_SUB_RD_THR   8'hd1
`define HRLC_SUB_RET_ST   8'hda
`define HRLC_SUB_RD_LOG   8'hd5
`define HRLC_SUB_WR_LOG   8'hd6
// commands still executed while locked
`define HRLC_LOCKED_OK    8'he5, 8'h90, 8'hec, 8'he3, 8'he1, 8'h00, 8'he4, 8'hef, 8'hc6, 8'he6, 8'he2, 8'he0, 8'he8

// ============================================================
// signatures in the cylinder registers
`define HRLC_SIG_LO       8'h4f
`define HRLC_SIG_HI       8'hc2
`define HRLC_EXC_LO       8'hf4
`define HRLC_EXC_HI       8'h2c

// ============================================================
// sector layouts
`define HRLC_SECT_LAST    10'd511
`define HRLC_THR_VER      16'h0010
`define HRLC_ENTRY_FIRST  10'd2
`define HRLC_ENTRY_END    10'd362
`define HRLC_ENTRY_LEN    10'd12
`define HRLC_ENTRY_NIDS   5'd12
`define HRLC_ATTR_IDS     {8'd196, 8'd213, 8'd229, 8'd203, 8'd204, 8'd199, 8'd232, 8'd12, 8'd241, 8'd242, 8'd214, 8'd215}
`define HRLC_ENT_SPARE    5'd0
`define HRLC_ENT_ERASE    5'd2
`define HRLC_LOG_VER      16'h0001
`define HRLC_LOG_DIR      8'h00
`define HRLC_LOG_VS_LO    8'h80
`define HRLC_LOG_VS_HI    8'h9f
`define HRLC_DIR_FIRST    10'd256
`define HRLC_DIR_END      10'd320
`define HRLC_LOG_SECTORS  8'h10
`define HRLC_CODE_FIRST   10'd32
`define HRLC_CODE_LAST    10'd64

// ============================================================
// feature bits of the lock command and identify word bits
`define HRLC_FEAT_LOCK    0
`define HRLC_FEAT_UNLOCK  1
`define HRLC_FEAT_ERASE   2
`define HRLC_ID_EN_BIT    10

// ============================================================
// register word indices and event bits
`define HRLC_REG_STATUS   2'h0
`define HRLC_REG_MASK     2'h1
`define HRLC_REG_THR      2'h2
`define HRLC_REG_LOCK     2'h3
`define HRLC_EV_DONE      0
`define HRLC_EV_ERR       1
`define HRLC_EV_HEALTH    2
`define HRLC_EV_LOCK      3

`endif

// *** hrlc_pkg.sv ***
/*
 * types of the health-report and host-lock command block.
 * assumes nothing; every user names hrlc_pkg:: explicitly.
 */
package hrlc_pkg;

	// ============================================================
	// command state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,	// waiting for a command
		ST_SEND = 3'b010,	// data-in sector to the host
		ST_RECV = 3'b100	// data-out sector from the host
	} hrlc_state_t;

	// source of the sector being sent
	typedef enum logic [1:0] {
		SRC_THR  = 2'h0,	// threshold table
		SRC_DIR  = 2'h1,	// log directory
		SRC_ZERO = 2'h2		// empty vendor log
	} hrlc_src_t;

	// task file as issued by the host controller
	typedef struct packed {
		logic [7:0] feature;
		logic [7:0] count;
		logic [7:0] sector;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
		logic [7:0] drv_head;
		logic [7:0] command;
	} hrlc_tf_t;

	// completion of a command
	typedef struct packed {
		logic       done;
		logic       error;
		logic [7:0] cyl_lo;
		logic [7:0] cyl_hi;
	} hrlc_resp_t;

	// whole state of the block
	typedef struct packed {
		hrlc_state_t  state;
		hrlc_src_t    src;
		logic         rx_lock;
		logic [2:0]   feat;
		logic [9:0]   idx;
		logic [7:0]   sum;
		logic [7:0]   byte_r;
		logic [263:0] code_in;
		logic [263:0] code;
		logic         enabled;
		logic         locked;
		hrlc_resp_t   resp;
		logic         pass;
		logic [3:0]   status;
		logic [3:0]   mask;
		logic [15:0]  thr;
		logic [15:0]  rdata;
		logic [1:0]   hsync;
		logic         hprev;
	} hrlc_regs_t;

endpackage

// *** hrlc_cmd.sv ***
/*
 * health-report commands and host-bound lock command of the card.
 * assumes one clock, a synchronous reset, a host controller that waits for
 * cmd_ready and for resp.done, and a hard-reset pin from outside the clock.
 */
// Design decisions made here: the strobed register port and the placing of the registers.
// Overview of operation
// - health subcommands need 4Fh/C2h cylinder signature
// - threshold sector: version, thirty entries, checksum
// - entries: id, threshold; only 196, 229 nonzero
// - exceeded threshold returns F4h/2Ch in cylinders
// - otherwise cylinders keep the loaded signature
// - decode log directory, vendor logs, reserved
// - directory: version 1, sixteen sectors per vendor log
// - log write only to vendor logs
// - lock data is one sector, code bytes 32-64
// - lock bit stores code, enables locking
// - stored code locks at next hard reset
// - locked: only listed commands and the lock command run
// - unlock needs unlock bit and matching code
// - erase bit with code clears lock
// - several feature bits set: reject with error
// - identify word 128 bits 11:10 show lock
`include "hrlc_defs.svh"

module hrlc_cmd (
	input  wire logic               clock,        // 100 MHz card clock
	input  wire logic               srst,         // synchronous reset, high
	input  wire logic               ce,           // clock enable, freezes all state
	input  wire logic               hard_rst_n,   // hard-reset pin, low active, asynchronous
	input  wire logic               cmd_valid,    // task file holds a new command
	output logic                    cmd_ready,    // block is free to take a command
	input  wire hrlc_pkg::hrlc_tf_t tf,           // task file contents
	input  wire logic               spare_exceed, // spare-block count past threshold
	input  wire logic               erase_exceed, // erase count past threshold
	output logic                    dout_valid,   // sector byte offered to host
	output logic [7:0]              dout_byte,    // sector byte
	input  wire logic               dout_ready,   // host takes the byte
	input  wire logic               din_valid,    // host offers a sector byte
	input  wire logic [7:0]         din_byte,     // sector byte from host
	output logic                    din_ready,    // block takes the byte
	output hrlc_pkg::hrlc_resp_t    resp,         // completion, cylinders
	output logic                    cmd_pass,     // forward command to the card core
	output logic [15:0]             id_word128,   // identify word with lock bits
	input  wire logic [1:0]         reg_addr,     // register word index
	input  wire logic [15:0]        reg_wdata,    // register write data
	input  wire logic               reg_we,       // register write strobe
	input  wire logic               reg_re,       // register read strobe
	output logic [15:0]             reg_rdata,    // read data, cycle after reg_re
	output logic                    irq           // unmasked event pending
);

	// ============================================================
	// state
	hrlc_pkg::hrlc_regs_t r;    // registered state
	hrlc_pkg::hrlc_regs_t n;    // next state
	logic [3:0]           ev;   // events of this cycle
	logic                 take; // command taken this cycle
	logic                 sig;  // cylinder signature present
	logic                 match;// received code equals stored code
	logic [7:0]           sum_nxt;

	// ============================================================
	// functions
	// command allowed while locked
	function automatic logic allowed(input logic [7:0] c);
		allowed = c inside {`HRLC_LOCKED_OK};
	endfunction

	// vendor host log address
	function automatic logic vendor_log(input logic [7:0] a);
		vendor_log = (a >= `HRLC_LOG_VS_LO) && (a <= `HRLC_LOG_VS_HI);
	endfunction

	// byte at offset i of the sector from source s
	function automatic logic [7:0] gen(input hrlc_pkg::hrlc_src_t s, input logic [9:0] i,
	                                   input logic [7:0] sm, input logic [15:0] th);
		logic [9:0]  rel;
		logic [4:0]  e;
		logic [9:0]  o;
		logic [95:0] ids;
		rel = 10'(i - `HRLC_ENTRY_FIRST);
		e   = 5'(rel / `HRLC_ENTRY_LEN);
		o   = 10'(rel % `HRLC_ENTRY_LEN);
		ids = `HRLC_ATTR_IDS;
		gen = 8'h00;
		case (s)
			hrlc_pkg::SRC_THR: begin
				if (i == `HRLC_SECT_LAST) begin
					gen = 8'(8'h00 - sm);
				end else if (i < `HRLC_ENTRY_FIRST) begin
					gen = 8'(i[0] ? `HRLC_THR_VER >> 8 : `HRLC_THR_VER);
				end else if (i < `HRLC_ENTRY_END) begin
					if (o == 10'd0 && e < `HRLC_ENTRY_NIDS) begin
						gen = ids[8 * (11 - 32'(e)) +: 8];
					end else if (o == 10'd1 && e == `HRLC_ENT_SPARE) begin
						gen = th[7:0];
					end else if (o == 10'd1 && e == `HRLC_ENT_ERASE) begin
						gen = th[15:8];
					end
				end
			end
			hrlc_pkg::SRC_DIR: begin
				if (i < `HRLC_ENTRY_FIRST) begin
					gen = 8'(i[0] ? `HRLC_LOG_VER >> 8 : `HRLC_LOG_VER);
				end else if (i >= `HRLC_DIR_FIRST && i < `HRLC_DIR_END && !i[0]) begin
					gen = `HRLC_LOG_SECTORS;
				end
			end
			default: gen = 8'h00;
		endcase
	endfunction

	// ============================================================
	// ports from state
	assign cmd_ready  = (r.state == hrlc_pkg::ST_IDLE);
	assign take       = ce && cmd_ready && cmd_valid;
	assign sig        = (tf.cyl_lo == `HRLC_SIG_LO) && (tf.cyl_hi == `HRLC_SIG_HI);
	assign match      = (r.code_in == r.code);
	assign sum_nxt    = 8'(r.sum + r.byte_r);
	assign dout_valid = (r.state == hrlc_pkg::ST_SEND);
	assign dout_byte  = r.byte_r;
	assign din_ready  = (r.state == hrlc_pkg::ST_RECV);
	assign resp       = r.resp;
	assign cmd_pass   = r.pass;
	assign reg_rdata  = r.rdata;
	assign irq        = |(r.status & r.mask);
	assign id_word128 = 16'({r.locked, r.enabled}) << `HRLC_ID_EN_BIT;

	// ============================================================
	// next state
	always_comb begin
		n           = r;
		ev          = 4'h0;
		n.resp.done = 1'b0;
		n.pass      = 1'b0;
		n.rdata     = 16'h0000;
		// hard-reset pin through two flops, lock re-arms on its assertion
		n.hsync     = {r.hsync[0], hard_rst_n};
		n.hprev     = r.hsync[1];
		case (r.state)
			// take and decode a command
			hrlc_pkg::ST_IDLE: begin
				if (take) begin
					n.resp.error  = 1'b0;
					n.resp.cyl_lo = tf.cyl_lo;
					n.resp.cyl_hi = tf.cyl_hi;
					n.idx         = 10'd0;
					n.sum         = 8'h00;
					n.feat        = tf.feature[2:0];
					if (tf.command == `HRLC_CMD_LOCK) begin
						if ($countones(tf.feature[2:0]) > 1) begin
							n.resp.done  = 1'b1;
							n.resp.error = 1'b1;
						end else begin
							n.state   = hrlc_pkg::ST_RECV;
							n.rx_lock = 1'b1;
						end
					end else if (r.locked && !allowed(tf.command)) begin
						n.resp.done  = 1'b1;
						n.resp.error = 1'b1;
					end else if (tf.command != `HRLC_CMD_SMART) begin
						n.pass = 1'b1;
					end else if (!sig) begin
						n.resp.done  = 1'b1;
						n.resp.error = 1'b1;
					end else begin
						case (tf.feature)
							`HRLC_SUB_RD_THR: begin
								n.state  = hrlc_pkg::ST_SEND;
								n.src    = hrlc_pkg::SRC_THR;
								n.byte_r = gen(hrlc_pkg::SRC_THR, 10'd0, 8'h00, r.thr);
							end
							`HRLC_SUB_RET_ST: begin
								n.resp.done = 1'b1;
								if (spare_exceed || erase_exceed) begin
									n.resp.cyl_lo       = `HRLC_EXC_LO;
									n.resp.cyl_hi       = `HRLC_EXC_HI;
									ev[`HRLC_EV_HEALTH] = 1'b1;
								end
							end
							`HRLC_SUB_RD_LOG: begin
								if (tf.sector == `HRLC_LOG_DIR) begin
									n.state  = hrlc_pkg::ST_SEND;
									n.src    = hrlc_pkg::SRC_DIR;
									n.byte_r = gen(hrlc_pkg::SRC_DIR, 10'd0, 8'h00, r.thr);
								end else if (vendor_log(tf.sector)) begin
									n.state  = hrlc_pkg::ST_SEND;
									n.src    = hrlc_pkg::SRC_ZERO;
									n.byte_r = 8'h00;
								end else begin
									n.resp.done  = 1'b1;
									n.resp.error = 1'b1;
								end
							end
							`HRLC_SUB_WR_LOG: begin
								if (vendor_log(tf.sector)) begin
									n.state   = hrlc_pkg::ST_RECV;
									n.rx_lock = 1'b0;
								end else begin
									n.resp.done  = 1'b1;
									n.resp.error = 1'b1;
								end
							end
							default: begin
								n.resp.done  = 1'b1;
								n.resp.error = 1'b1;
							end
						endcase
					end
				end
			end
			// one sector to the host, checksum built on the fly
			hrlc_pkg::ST_SEND: begin
				if (ce && dout_ready) begin
					n.sum = sum_nxt;
					if (r.idx == `HRLC_SECT_LAST) begin
						n.state     = hrlc_pkg::ST_IDLE;
						n.resp.done = 1'b1;
					end else begin
						n.idx    = 10'(r.idx + 10'd1);
						n.byte_r = gen(r.src, 10'(r.idx + 10'd1), sum_nxt, r.thr);
					end
				end
			end
			// one sector from the host; lock code shifted in
			hrlc_pkg::ST_RECV: begin
				if (ce && din_valid) begin
					n.idx = 10'(r.idx + 10'd1);
					if (r.rx_lock && r.idx >= `HRLC_CODE_FIRST && r.idx <= `HRLC_CODE_LAST) begin
						n.code_in = {r.code_in[255:0], din_byte};
					end
					if (r.idx == `HRLC_SECT_LAST) begin
						n.state     = hrlc_pkg::ST_IDLE;
						n.resp.done = 1'b1;
						if (r.rx_lock && r.feat[`HRLC_FEAT_LOCK]) begin
							n.code    = r.code_in;
							n.enabled = 1'b1;
						end else if (r.rx_lock && r.feat[`HRLC_FEAT_UNLOCK]) begin
							if (r.enabled && match) begin
								n.locked = 1'b0;
							end else begin
								n.resp.error = 1'b1;
							end
						end else if (r.rx_lock && r.feat[`HRLC_FEAT_ERASE]) begin
							if (r.enabled && match) begin
								n.enabled = 1'b0;
								n.locked  = 1'b0;
								n.code    = '0;
							end else begin
								n.resp.error = 1'b1;
							end
						end
					end
				end
			end
			default: n.state = hrlc_pkg::ST_IDLE;
		endcase
		// hard reset: abort and fall back to the locked mode if armed
		if (r.hprev && !r.hsync[1]) begin
			n.state  = hrlc_pkg::ST_IDLE;
			n.locked = r.enabled;
		end
		// events
		ev[`HRLC_EV_DONE] = n.resp.done;
		ev[`HRLC_EV_ERR]  = n.resp.done && n.resp.error;
		ev[`HRLC_EV_LOCK] = (n.locked != r.locked) || (n.enabled != r.enabled);
		// register port
		if (reg_we) begin
			case (reg_addr)
				`HRLC_REG_STATUS: n.status = r.status & ~reg_wdata[3:0];
				`HRLC_REG_MASK:   n.mask   = reg_wdata[3:0];
				`HRLC_REG_THR:    n.thr    = reg_wdata;
				default:          n.mask   = r.mask;
			endcase
		end
		if (reg_re) begin
			case (reg_addr)
				`HRLC_REG_STATUS: n.rdata = {12'h000, r.status};
				`HRLC_REG_MASK:   n.rdata = {12'h000, r.mask};
				`HRLC_REG_THR:    n.rdata = r.thr;
				default:          n.rdata = {14'h0000, r.locked, r.enabled};
			endcase
		end
		// a new event wins over a clear in the same cycle
		n.status = n.status | ev;
	end

	// ============================================================
	// state register
	always_ff @(posedge clock) begin
		if (srst) begin
			r       <= '0;
			r.state <= hrlc_pkg::ST_IDLE;
			r.hsync <= 2'b11;
			r.hprev <= 1'b1;
		end else if (ce) begin
			r <= n;
		end
	end

	// ============================================================
	// checks
	property p_sig;
		@(posedge clock) disable iff (srst)
		take && tf.command == `HRLC_CMD_SMART && !r.locked && !sig |=> resp.done && resp.error;
	endproperty
	a_sig: assert property (p_sig) else $error("health command ran without signature");

	property p_exc;
		@(posedge clock) disable iff (srst)
		take && !r.locked && tf.command == `HRLC_CMD_SMART && sig &&
		tf.feature == `HRLC_SUB_RET_ST && (spare_exceed || erase_exceed)
		|=> resp.done && resp.cyl_lo == `HRLC_EXC_LO && resp.cyl_hi == `HRLC_EXC_HI;
	endproperty
	a_exc: assert property (p_exc) else $error("exceeded status not reported");

	property p_ok;
		@(posedge clock) disable iff (srst)
		take && !r.locked && tf.command == `HRLC_CMD_SMART && sig &&
		tf.feature == `HRLC_SUB_RET_ST && !spare_exceed && !erase_exceed
		|=> resp.done && !resp.error && resp.cyl_lo == `HRLC_SIG_LO && resp.cyl_hi == `HRLC_SIG_HI;
	endproperty
	a_ok: assert property (p_ok) else $error("signature not kept on healthy status");

	property p_ver;
		@(posedge clock) disable iff (srst)
		take && !r.locked && tf.command == `HRLC_CMD_SMART && sig && tf.feature == `HRLC_SUB_RD_THR
		&& !(r.hprev && !r.hsync[1]) |=> dout_valid && dout_byte == 8'h10;
	endproperty
	a_ver: assert property (p_ver) else $error("threshold version byte wrong");

	property p_wlog;
		@(posedge clock) disable iff (srst)
		take && !r.locked && tf.command == `HRLC_CMD_SMART && sig &&
		tf.feature == `HRLC_SUB_WR_LOG && !vendor_log(tf.sector) |=> resp.error && !din_ready;
	endproperty
	a_wlog: assert property (p_wlog) else $error("non-vendor log accepted for write");

	property p_filter;
		@(posedge clock) disable iff (srst)
		take && r.locked && !allowed(tf.command) && tf.command != `HRLC_CMD_LOCK
		|=> resp.error && !cmd_pass;
	endproperty
	a_filter: assert property (p_filter) else $error("refused command passed while locked");

	property p_multi;
		@(posedge clock) disable iff (srst)
		take && tf.command == `HRLC_CMD_LOCK && $countones(tf.feature[2:0]) > 1
		|=> resp.done && resp.error && $stable(r.code) && cmd_ready;
	endproperty
	a_multi: assert property (p_multi) else $error("several lock bits not rejected");

	property p_bad_code;
		@(posedge clock) disable iff (srst)
		ce && r.state == hrlc_pkg::ST_RECV && din_valid && r.idx == `HRLC_SECT_LAST &&
		r.rx_lock && (r.feat[`HRLC_FEAT_UNLOCK] || r.feat[`HRLC_FEAT_ERASE]) && !match &&
		!(r.hprev && !r.hsync[1])
		|=> resp.error && $stable(r.locked) && $stable(r.enabled);
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("wrong code changed lock state");

	property p_rearm;
		@(posedge clock) disable iff (srst)
		ce && r.hprev && !r.hsync[1] |=> r.locked == $past(r.enabled) && id_word128[11] == r.locked;
	endproperty
	a_rearm: assert property (p_rearm) else $error("hard reset did not re-arm lock");

endmodule

// *** hrlc_host.sv ***
/*
 * host controller model: offers task files and moves sector bytes with stalls.
 * assumes the block under test shares its clock and answers as handed over.
 */
module hrlc_host (
	input  wire logic                 clock,      // card clock
	output hrlc_pkg::hrlc_tf_t        tf,         // task file
	output logic                      cmd_valid,  // command offered
	input  wire logic                 cmd_ready,  // block idle
	input  wire logic                 dout_valid, // byte from block
	input  wire logic [7:0]           dout_byte,  // byte value
	output logic                      dout_ready, // host accepts
	output logic                      din_valid,  // byte to block
	output logic [7:0]                din_byte,   // byte value
	input  wire logic                 din_ready,  // block takes byte
	input  wire hrlc_pkg::hrlc_resp_t resp,       // completion
	input  wire logic                 cmd_pass    // forwarded to core
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]           rd_buf [512]; // sector read back
	logic [7:0]           wr_buf [512]; // sector to send
	hrlc_pkg::hrlc_resp_t got;          // captured completion
	logic                 passed;       // command went to core
	logic                 hung;         // no completion seen
	initial begin
		tf = '0;
		cmd_valid = 1'b0;
		dout_ready = 1'b0;
		din_valid = 1'b0;
		din_byte = 8'h00;
	end
	// ============================================================
	// one command: offer, move bytes, wait for done or forward
	task automatic run(input hrlc_pkg::hrlc_tf_t t);
		int   n;
		int   k;
		logic v;
		n = 0;
		k = 0;
		hung = 1'b1;
		passed = 1'b0;
		@(posedge clock);
		cmd_valid <= 1'b1;
		tf <= t;
		repeat (4000) begin
			@(posedge clock);
			if (cmd_valid && cmd_ready) cmd_valid <= 1'b0;
			if (dout_valid && dout_ready) begin
				rd_buf[n % 512] = dout_byte;
				n++;
			end
			if (din_valid && din_ready) k++;
			if (resp.done || cmd_pass) begin
				got = resp;
				passed = cmd_pass;
				hung = 1'b0;
				// release once, in the step that ends the command
				cmd_valid <= 1'b0;
				din_valid <= 1'b0;
				dout_ready <= 1'b0;
				break;
			end
			dout_ready <= ($urandom % 3) != 0;
			// bytes only after data ready, one sector, released line inverted
			v = din_ready && k < 512 && ($urandom % 3) != 0;
			din_valid <= v;
			din_byte <= v ? wr_buf[k % 512] : ~wr_buf[k % 512];
		end
	endtask
endmodule

// *** hrlc_cmd_tb_top.sv ***
/*
 * self-checking bench of the health-report and host-lock command block.
 * assumes hrlc_host as the far side and registers reached through the plain port.
 */
`define CMP(g, e) cmp_v(32'(g), 32'(e))
module hrlc_cmd_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clock = 1'b0; // 100 MHz
	logic                 srst, ce, hard_rst_n, spare, erase, cmd_valid, cmd_ready;
	logic                 dout_valid, dout_ready, din_valid, din_ready, cmd_pass, irq;
	logic                 reg_we, reg_re;
	logic [7:0]           dout_byte, din_byte;
	logic [15:0]          id_w, reg_wdata, reg_rdata, r, th;
	logic [1:0]           reg_addr;
	hrlc_pkg::hrlc_tf_t   tf;
	hrlc_pkg::hrlc_resp_t resp;
	int                   bad_count, n_checks, en, lk, exp_s[512];
	logic [7:0]           code [33];     // lock code of the test
	logic [7:0]           ok [13] = '{8'he5, 8'h90, 8'hec, 8'he3, 8'he1, 8'h00, 8'he4,
		8'hef, 8'hc6, 8'he6, 8'he2, 8'he0, 8'he8}; // commands run while locked
	logic [7:0]           lg [7] = '{8'h00, 8'h80, 8'h9f, 8'ha0, 8'ha1, 8'ha2, 8'h40};
	int                   ids [12] = '{196, 213, 229, 203, 204, 199, 232, 12, 241, 242, 214, 215};
	always #5 clock = ~clock;
	hrlc_cmd DUT (.clock(clock), .srst(srst), .ce(ce), .hard_rst_n(hard_rst_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .tf(tf), .spare_exceed(spare),
		.erase_exceed(erase), .dout_valid(dout_valid), .dout_byte(dout_byte),
		.dout_ready(dout_ready), .din_valid(din_valid), .din_byte(din_byte),
		.din_ready(din_ready), .resp(resp), .cmd_pass(cmd_pass), .id_word128(id_w),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .irq(irq));
	hrlc_host host (.clock(clock), .tf(tf), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.dout_valid(dout_valid), .dout_byte(dout_byte), .dout_ready(dout_ready),
		.din_valid(din_valid), .din_byte(din_byte), .din_ready(din_ready),
		.resp(resp), .cmd_pass(cmd_pass));
	// ============================================================
	// comparison, verdict, bus tasks
	task automatic cmp_v(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_we <= 1'b0;
		#1;
	endtask
	task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_re <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask
	// runs one command and expects the error flag given
	task automatic go(input hrlc_pkg::hrlc_tf_t t, input int e);
		host.run(t);
		if (host.hung) begin
			bad_count++;
			final_report();
		end
		if (e < 2) `CMP(host.got.error, e);
	endtask
	function automatic hrlc_pkg::hrlc_tf_t sm(input logic [7:0] s, input logic [7:0] a);
		return {s, 8'h01, a, 8'h4f, 8'hc2, 8'ha0, 8'hb0};
	endfunction
	function automatic hrlc_pkg::hrlc_tf_t lt(input logic [7:0] f);
		return {f, 8'h01, 8'h00, 8'h00, 8'h00, 8'ha0, 8'h83};
	endfunction
	task automatic sect;
		for (int i = 0; i < 512; i++) `CMP(host.rd_buf[i], exp_s[i]);
	endtask
	task automatic set_code(input int wrong);
		foreach (host.wr_buf[i]) host.wr_buf[i] = 8'h00;
		foreach (code[i]) host.wr_buf[32 + i] = code[i] ^ 8'(wrong);
	endtask
	task automatic chk_lock;
		repeat (2) @(posedge clock);
		#1;
		`CMP(id_w, (lk << 11) | (en << 10));
		reg_rd(2'h3, r);
		`CMP(r, (lk << 1) | en);
	endtask
	task automatic hard_pulse;
		hard_rst_n <= 1'b0;
		repeat (5) @(posedge clock);
		hard_rst_n <= 1'b1;
		repeat (5) @(posedge clock);
	endtask
	// ============================================================
	// main sequence
	initial begin
		int sum;
		srst = 1'b1;
		ce = 1'b1;
		hard_rst_n = 1'b1;
		{spare, erase, reg_we, reg_re, reg_addr, reg_wdata} = '0;
		{bad_count, n_checks, en, lk} = '0;
		sum = $urandom(96054);
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		reg_wr(2'h3, 16'hffff);
		for (int a = 0; a < 4; a++) begin
			reg_rd(2'(a), r);
			`CMP(r, 0);
		end
		chk_lock();
		$display("test reset values done");
		th = 16'($urandom);
		reg_wr(2'h2, th);
		reg_wr(2'h1, 16'h000f);
		go(sm(8'hd1, 8'h00), 0);
		exp_s = '{default: 0};
		exp_s[0] = 8'h10;
		sum = 0;
		for (int i = 0; i < 12; i++) exp_s[2 + 12 * i] = ids[i];
		exp_s[3] = th[7:0];
		exp_s[27] = th[15:8];
		for (int i = 0; i < 511; i++) sum += exp_s[i];
		exp_s[511] = (256 - sum % 256) % 256;
		sect();
		reg_rd(2'h0, r);
		`CMP(r[0], 1);
		`CMP(irq, 1);
		reg_wr(2'h0, 16'h000f);
		`CMP(irq, 0);
		reg_wr(2'h1, 16'h0000);
		go(sm(8'hda, 8'h00), 0);
		`CMP(irq, 0);
		reg_wr(2'h1, 16'h000f);
		`CMP(irq, 1);
		reg_wr(2'h0, 16'h000f);
		// clock enable low: a register write must not land
		ce <= 1'b0;
		reg_wr(2'h1, 16'h0005);
		ce <= 1'b1;
		reg_rd(2'h1, r);
		`CMP(r, 16'h000f);
		$display("test thresholds and events done");
		for (int c = 0; c < 4; c++) begin
			spare <= c[0];
			erase <= c[1];
			go(sm(8'hda, 8'h00), 0);
			`CMP(host.got.cyl_lo, c ? 8'hf4 : 8'h4f);
			`CMP(host.got.cyl_hi, c ? 8'h2c : 8'hc2);
		end
		go({8'hda, 8'h01, 8'h00, 8'h4f, 8'h00, 8'ha0, 8'hb0}, 1);
		go({8'hd1, 8'h01, 8'h00, 8'h00, 8'hc2, 8'ha0, 8'hb0}, 1);
		$display("test return status done");
		foreach (lg[j]) begin
			go(sm(8'hd5, lg[j]), (lg[j] == 0 || lg[j][7:5] == 3'b100) ? 0 : 1);
			exp_s = '{default: 0};
			exp_s[0] = lg[j] == 0;
			for (int i = 256; i < 320; i += 2) exp_s[i] = lg[j] == 0 ? 16 : 0;
			if (!host.got.error) sect();
		end
		foreach (host.wr_buf[i]) host.wr_buf[i] = 8'($urandom);
		go(sm(8'hd6, 8'h85), 0);
		go(sm(8'hd6, 8'h00), 1);
		go(sm(8'hd6, 8'ha0), 1);
		$display("test logs done");
		foreach (code[i]) code[i] = 8'($urandom);
		set_code(0);
		go(lt(8'h01), 0);
		en = 1;
		chk_lock();
		for (int f = 3; f < 8; f++) if (f != 4) go(lt(8'(f)), 1);
		chk_lock();
		hard_pulse();
		lk = 1;
		chk_lock();
		foreach (ok[i]) begin
			go({40'h0, 8'ha0, ok[i]}, 2);
			`CMP(host.passed, 1);
		end
		go({40'h0, 8'ha0, 8'h20}, 1);
		go({40'h0, 8'ha0, 8'hc8}, 1);
		go(sm(8'hd1, 8'h00), 1);
		set_code(1);
		go(lt(8'h02), 1);
		chk_lock();
		set_code(0);
		go(lt(8'h02), 0);
		lk = 0;
		chk_lock();
		go({40'h0, 8'ha0, 8'h20}, 2);
		`CMP(host.passed, 1);
		set_code(1);
		go(lt(8'h04), 1);
		set_code(0);
		go(lt(8'h04), 0);
		en = 0;
		chk_lock();
		go(lt(8'h04), 1);
		hard_pulse();
		chk_lock();
		$display("test host lock done");
		final_report();
	end
endmodule
